// *** rtl/dsc_defines.svh ***
`ifndef DSC_DEFINES_SVH
`define DSC_DEFINES_SVH

// wishbone register byte offsets
`define DSC_R_CTRL 8'h00
`define DSC_R_PLLDIV 8'h04
`define DSC_R_LOOKUP 8'h08
`define DSC_R_STATUS 8'h0c
`define DSC_R_ISTAT 8'h10
`define DSC_R_IMASK 8'h14
`define DSC_R_IDENT 8'h18
`define DSC_R_PWRCFG 8'h1c

// control bits
`define DSC_C_START 0
`define DSC_C_PLL 1
`define DSC_C_SUB0 2
`define DSC_C_ABORT 3

// interrupt bits
`define DSC_I_DONE 0
`define DSC_I_FAIL 1
`define DSC_I_LOCK 2

// device register addresses
`define DSC_A_PORT 15'h000
`define DSC_A_TYPE 15'h003
`define DSC_A_ID_LO 15'h004
`define DSC_A_ID_HI 15'h005
`define DSC_A_GRADE 15'h006
`define DSC_A_PWR 15'h011
`define DSC_A_CLK_PD 15'h080
`define DSC_A_ALIGN_PD 15'h081
`define DSC_A_PLL_EN 15'h083
`define DSC_A_PLL_LOCK 15'h084
`define DSC_A_FBCNT 15'h085
`define DSC_A_LF_A 15'h087
`define DSC_A_LF_B 15'h088
`define DSC_A_LF_C 15'h089
`define DSC_A_CP_A 15'h08a
`define DSC_A_OUT_DIV 15'h08b
`define DSC_A_REF_DIV 15'h08c
`define DSC_A_REG 15'h08d
`define DSC_A_DP_A 15'h12d
`define DSC_A_DP_B 15'h146
`define DSC_A_PWR_MACH 15'h1b0
`define DSC_A_CP_B 15'h1b9
`define DSC_A_OSC_CTL 15'h1bc
`define DSC_A_OSC_PWR 15'h1be
`define DSC_A_OSC_CAL 15'h1bf
`define DSC_A_LOCK_LEN 15'h1c0
`define DSC_A_CP_C 15'h1c1
`define DSC_A_VARACTOR 15'h1c4
`define DSC_A_SER_A 15'h232
`define DSC_A_CLK_CFG 15'h2a4
`define DSC_A_SER_B 15'h333

// device register values
`define DSC_V_SOFT_RESET 8'hbd
`define DSC_V_PORT_4W 8'h3c
`define DSC_V_ALIGN_SUB1 8'h00
`define DSC_V_ALIGN_SUB0 8'h10
`define DSC_V_DP_A 8'h8b
`define DSC_V_DP_B 8'h01
`define DSC_V_CLK_CFG 8'hff
`define DSC_V_SER_A 8'hff
`define DSC_V_SER_B 8'h01
`define DSC_V_LF_A 8'h62
`define DSC_V_LF_B 8'hc9
`define DSC_V_LF_C 8'h0e
`define DSC_V_CP_A 8'h12
`define DSC_V_REG 8'h7b
`define DSC_V_PWR_MACH 8'h00
`define DSC_V_CP_B 8'h24
`define DSC_V_OSC_CTL 8'h0d
`define DSC_V_OSC_PWR 8'h02
`define DSC_V_OSC_CAL 8'h8e
`define DSC_V_LOCK_LEN 8'h2a
`define DSC_V_CP_C 8'h2a
`define DSC_V_VARACTOR 8'h7e
`define DSC_V_PLL_EN 8'h10
`define DSC_LOCK_BIT 1

// command word builders: read flag, address, data
`define DSC_WR(a, v) {1'b0, a, v}
`define DSC_RD(a) {1'b1, a, 8'h00}

// sequence positions
`define DSC_STEP_BASE_LAST 6'd13
`define DSC_STEP_PLL_EN 6'd31
`define DSC_STEP_POLL 6'd32

// timing
`define DSC_LOCK_POLLS 16'd1000
`define DSC_CLK_NS 8
`define DSC_SCLK_MIN_NS 100
`define DSC_SCLK_HALF ((`DSC_SCLK_MIN_NS / 2 + `DSC_CLK_NS - 1) / `DSC_CLK_NS)
`define DSC_FRAME_BITS 5'd24

`endif

// *** rtl/dsc_pkg.sv ***
package dsc_pkg;

   typedef enum logic [1:0] {
      DSC_IDLE = 2'b00,
      DSC_ISSUE = 2'b01,
      DSC_WAIT = 2'b11,
      DSC_NEXT = 2'b10
   } dsc_state_t;

   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic mosi;
      logic oe;
      logic busy;
      logic done;
      logic [3:0] cnt;
      logic [4:0] bits;
      logic [23:0] sh;
      logic [7:0] rx;
      logic [2:0] sync;
      logic sdo_f;
   } dsc_spi_st_t;

   localparam dsc_spi_st_t DSC_SPI_RST = '{cs_n: 1'b1, default: '0};

   typedef struct packed {
      dsc_state_t state;
      logic [5:0] step;
      logic [15:0] polls;
      logic go;
      logic start;
      logic abort;
      logic use_pll;
      logic sub0;
      logic [3:0] pd_dacs;
      logic [7:0] pd_clks;
      logic [23:0] div;
      logic [22:0] lut;
      logic [31:0] ident;
      logic busy;
      logic done;
      logic fail;
      logic locked;
      logic [2:0] istat;
      logic [2:0] imask;
      logic ack;
      logic irq;
      logic [31:0] rdata;
   } dsc_main_st_t;

endpackage

// *** rtl/dsc_spi_xfer.sv ***
`timescale 1ns/1ps
`include "dsc_defines.svh"

module dsc_spi_xfer
   import dsc_pkg::*;
#(
   parameter int HALF = `DSC_SCLK_HALF
) (
   input logic ref_clk_i,
   input logic reset_n_i,
   input logic start_i,
   input logic rd_i,
   input logic [14:0] addr_i,
   input logic [7:0] wdata_i,
   input logic sdo_i,
   output logic done_o,
   output logic [7:0] rdata_o,
   output logic sclk_o,
   output logic cs_n_o,
   output logic sdio_o,
   output logic sdio_oe_o
);

   dsc_spi_st_t q, d;

   always_comb begin
      d = q;
      d.done = 1'b0;
      d.sync = {q.sync[1:0], sdo_i};
      // data line change counts once second and third stage agree
      if (q.sync[1] == q.sync[2]) begin
         d.sdo_f = q.sync[2];
      end
      if (!q.busy) begin
         if (start_i) begin
            // RULE_18 instruction word first
            d.sh = {rd_i, addr_i, wdata_i};
            d.mosi = rd_i;
            d.busy = 1'b1;
            d.cs_n = 1'b0;
            d.oe = 1'b1;
            d.bits = `DSC_FRAME_BITS;
            d.cnt = 4'h0;
         end
      end else if (q.cnt == 4'(HALF - 1)) begin
         d.cnt = 4'h0;
         if (q.bits == 5'h0) begin
            d.busy = 1'b0;
            d.cs_n = 1'b1;
            d.oe = 1'b0;
            d.mosi = 1'b0;
            d.done = 1'b1;
         end else if (!q.sclk) begin
            d.sclk = 1'b1;
         end else begin
            // falling edge: sample returned bit, present next one
            d.sclk = 1'b0;
            d.rx = {q.rx[6:0], q.sdo_f};
            d.sh = {q.sh[22:0], 1'b0};
            d.mosi = q.sh[22];
            d.bits = q.bits - 5'h1;
         end
      end else begin
         d.cnt = q.cnt + 4'h1;
      end
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         q <= DSC_SPI_RST;
      end else begin
         q <= d;
      end
   end

   assign done_o = q.done;
   assign rdata_o = q.rx;
   assign sclk_o = q.sclk;
   assign cs_n_o = q.cs_n;
   assign sdio_o = q.mosi;
   assign sdio_oe_o = q.oe;

   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);

   a_rw_bit_first: assert property ( // RULE_18
      start_i && !q.busy |=> !cs_n_o && !sclk_o && sdio_o == $past(rd_i))
      else $error("read flag not first on the data line");
   a_sclk_in_frame: assert property (sclk_o |-> !cs_n_o && sdio_oe_o)
      else $error("serial clock high outside a frame");
   a_done_ends_frame: assert property (done_o |-> cs_n_o && $past(!cs_n_o))
      else $error("done without a frame ending");

endmodule

// *** rtl/dsc_startup_host.sv ***
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
`include "dsc_defines.svh"

// What this block does
// RULE_01 - device shows product type code at 0x003; host reads and keeps it
// RULE_02 - product id high byte sits at 0x005, low byte at 0x004
// RULE_03 - 0x006 holds grade in upper nibble, revision in lower nibble
// RULE_04 - port, power and clocks first; datapath and link layers follow later
// RULE_05 - write 0xbd to register zero, then 0x3c for four-wire port
// RULE_06 - clear converter_power_down bits 7 and 2 to power band gap, master converter
// RULE_07 - converter power-down field converter_power_down[6:3] is zero with all four converters
// RULE_08 - clock power-down register clock_power_down is zero with all four converters
// RULE_09 - align_input_power_down gets zero for subclass 1, 0x10 for subclass 0
// RULE_10 - after any reset write the five fixed configuration values
// RULE_11 - with pll, write loop-filter, charge-pump and regulator values
// RULE_12 - with pll, write zero to pll_power_machine_cfg keeping pll blocks powered
// RULE_13 - with pll, write charge pump, oscillator, calibration, varactor values
// RULE_14 - with pll, write 0x2a to lock counter length pll_lock_counter_len
// RULE_15 - write dividers, feedback count and lookup values before pll enable
// RULE_16 - write 0x10 to pll_enable_ctrl last, then read pll_lock_status for lock
// RULE_17 - device sets pll_lock_status bit 1 once the pll is locked
// RULE_18 - each access opens with 16-bit word: read flag, 15-bit address
// RULE_19 - poll lock bit with bounded retries; flag failure if never locked
module dsc_startup_host
   import dsc_pkg::*;
#(
   parameter logic [15:0] LOCK_POLLS = `DSC_LOCK_POLLS,
   parameter int SCLK_HALF = `DSC_SCLK_HALF
) (
   input logic ref_clk_i,
   input logic reset_n_i,
   input logic wb_cyc_i,
   input logic wb_stb_i,
   input logic wb_we_i,
   input logic [7:0] wb_adr_i,
   input logic [3:0] wb_sel_i,
   input logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq_o,
   output logic spi_sclk_o,
   output logic spi_cs_n_o,
   output logic spi_sdio_o,
   output logic spi_sdio_oe_o,
   input logic spi_sdo_i
);

   dsc_main_st_t q, d;
   logic spi_done;
   logic [7:0] spi_rdata;
   logic [23:0] cmd;
   logic wb_req;
   logic [31:0] wv;
   logic rd_clr;
   logic [2:0] set;

   function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[8*i +: 8] = n[8*i +: 8];
         end
      end
      return r;
   endfunction

   // one command word per sequence position
   function automatic logic [23:0] step_cmd(input logic [5:0] s, input dsc_main_st_t c);
      logic [23:0] r;
      r = `DSC_RD(`DSC_A_PLL_LOCK);
      case (s)
         // RULE_04 port stage first
         // RULE_05 reset then release
         6'd0: r = `DSC_WR(`DSC_A_PORT, `DSC_V_SOFT_RESET);
         6'd1: r = `DSC_WR(`DSC_A_PORT, `DSC_V_PORT_4W);
         // RULE_01 product type read
         6'd2: r = `DSC_RD(`DSC_A_TYPE);
         // RULE_02 product id read
         6'd3: r = `DSC_RD(`DSC_A_ID_LO);
         6'd4: r = `DSC_RD(`DSC_A_ID_HI);
         // RULE_03 grade and revision
         6'd5: r = `DSC_RD(`DSC_A_GRADE);
         // RULE_06 band gap, master up
         // RULE_07 per-converter field
         6'd6: r = `DSC_WR(`DSC_A_PWR, {1'b0, c.pd_dacs, 3'h0});
         // RULE_08 converter clock power
         6'd7: r = `DSC_WR(`DSC_A_CLK_PD, c.pd_clks);
         // RULE_09 alignment input power
         6'd8: r = `DSC_WR(`DSC_A_ALIGN_PD, c.sub0 ? `DSC_V_ALIGN_SUB0 : `DSC_V_ALIGN_SUB1);
         // RULE_10 mandatory post-reset values
         6'd9: r = `DSC_WR(`DSC_A_DP_A, `DSC_V_DP_A);
         6'd10: r = `DSC_WR(`DSC_A_DP_B, `DSC_V_DP_B);
         6'd11: r = `DSC_WR(`DSC_A_CLK_CFG, `DSC_V_CLK_CFG);
         6'd12: r = `DSC_WR(`DSC_A_SER_A, `DSC_V_SER_A);
         6'd13: r = `DSC_WR(`DSC_A_SER_B, `DSC_V_SER_B);
         // RULE_11 loop filter, regulator
         6'd14: r = `DSC_WR(`DSC_A_LF_A, `DSC_V_LF_A);
         6'd15: r = `DSC_WR(`DSC_A_LF_B, `DSC_V_LF_B);
         6'd16: r = `DSC_WR(`DSC_A_LF_C, `DSC_V_LF_C);
         6'd17: r = `DSC_WR(`DSC_A_CP_A, `DSC_V_CP_A);
         6'd18: r = `DSC_WR(`DSC_A_REG, `DSC_V_REG);
         // RULE_12 pll blocks powered
         6'd19: r = `DSC_WR(`DSC_A_PWR_MACH, `DSC_V_PWR_MACH);
         // RULE_13 oscillator and pump
         6'd20: r = `DSC_WR(`DSC_A_CP_B, `DSC_V_CP_B);
         6'd21: r = `DSC_WR(`DSC_A_OSC_CTL, `DSC_V_OSC_CTL);
         6'd22: r = `DSC_WR(`DSC_A_OSC_PWR, `DSC_V_OSC_PWR);
         6'd23: r = `DSC_WR(`DSC_A_OSC_CAL, `DSC_V_OSC_CAL);
         // RULE_14 lock counter length
         6'd24: r = `DSC_WR(`DSC_A_LOCK_LEN, `DSC_V_LOCK_LEN);
         6'd25: r = `DSC_WR(`DSC_A_CP_C, `DSC_V_CP_C);
         6'd26: r = `DSC_WR(`DSC_A_VARACTOR, `DSC_V_VARACTOR);
         // RULE_15 dividers, count, lookup
         6'd27: r = `DSC_WR(`DSC_A_OUT_DIV, c.div[7:0]);
         6'd28: r = `DSC_WR(`DSC_A_REF_DIV, c.div[15:8]);
         6'd29: r = `DSC_WR(`DSC_A_FBCNT, c.div[23:16]);
         6'd30: r = {1'b0, c.lut};
         // RULE_16 enable comes last
         6'd31: r = `DSC_WR(`DSC_A_PLL_EN, `DSC_V_PLL_EN);
         default: r = `DSC_RD(`DSC_A_PLL_LOCK);
      endcase
      return r;
   endfunction

   assign cmd = step_cmd(q.step, q);

   always_comb begin
      d = q;
      d.start = 1'b0;
      d.go = 1'b0;
      wb_req = wb_cyc_i && wb_stb_i && !q.ack;
      wv = 32'h0;
      rd_clr = 1'b0;
      set = 3'h0;
      d.ack = wb_req;

      // register writes; configuration frozen while a sequence runs
      if (wb_req && wb_we_i) begin
         case (wb_adr_i)
            `DSC_R_CTRL: begin
               if (wb_sel_i[0] && !q.busy) begin
                  d.start = wb_dat_i[`DSC_C_START];
                  d.use_pll = wb_dat_i[`DSC_C_PLL];
                  d.sub0 = wb_dat_i[`DSC_C_SUB0];
               end
               if (wb_sel_i[0] && q.busy && wb_dat_i[`DSC_C_ABORT]) begin
                  d.abort = 1'b1;
               end
            end
            `DSC_R_PLLDIV: begin
               wv = wmerge({8'h00, q.div}, wb_dat_i, wb_sel_i);
               if (!q.busy) begin
                  d.div = wv[23:0];
               end
            end
            `DSC_R_LOOKUP: begin
               wv = wmerge({9'h000, q.lut}, wb_dat_i, wb_sel_i);
               if (!q.busy) begin
                  d.lut = wv[22:0];
               end
            end
            `DSC_R_PWRCFG: begin
               wv = wmerge({16'h0000, q.pd_clks, 4'h0, q.pd_dacs}, wb_dat_i, wb_sel_i);
               if (!q.busy) begin
                  d.pd_dacs = wv[3:0];
                  d.pd_clks = wv[15:8];
               end
            end
            `DSC_R_IMASK: begin
               if (wb_sel_i[0]) begin
                  d.imask = wb_dat_i[2:0];
               end
            end
            default: begin
            end
         endcase
      end

      // register reads; unmapped offsets read zero
      if (wb_req && !wb_we_i) begin
         case (wb_adr_i)
            `DSC_R_CTRL: d.rdata = {29'h0, q.sub0, q.use_pll, 1'b0};
            `DSC_R_PLLDIV: d.rdata = {8'h00, q.div};
            `DSC_R_LOOKUP: d.rdata = {9'h000, q.lut};
            `DSC_R_STATUS: d.rdata = {18'h0, q.step, 4'h0, q.locked, q.fail, q.done, q.busy};
            `DSC_R_ISTAT: begin
               d.rdata = {29'h0, q.istat};
               rd_clr = 1'b1;
            end
            `DSC_R_IMASK: d.rdata = {29'h0, q.imask};
            `DSC_R_IDENT: d.rdata = q.ident;
            `DSC_R_PWRCFG: d.rdata = {16'h0000, q.pd_clks, 4'h0, q.pd_dacs};
            default: d.rdata = 32'h0;
         endcase
      end

      case (q.state)
         DSC_IDLE: begin
            if (q.start) begin
               d.step = 6'h00;
               d.polls = 16'h0000;
               d.busy = 1'b1;
               d.done = 1'b0;
               d.fail = 1'b0;
               d.locked = 1'b0;
               d.abort = 1'b0;
               d.ident = 32'h0;
               d.state = DSC_ISSUE;
            end
         end
         DSC_ISSUE: begin
            d.go = 1'b1;
            d.state = DSC_WAIT;
         end
         DSC_WAIT: begin
            if (spi_done) begin
               // RULE_02 capture identity bytes
               if (cmd[23]) begin
                  case (cmd[22:8])
                     `DSC_A_TYPE: d.ident[7:0] = spi_rdata;
                     `DSC_A_ID_LO: d.ident[15:8] = spi_rdata;
                     `DSC_A_ID_HI: d.ident[23:16] = spi_rdata;
                     `DSC_A_GRADE: d.ident[31:24] = spi_rdata;
                     default: begin
                     end
                  endcase
               end
               if (q.abort) begin
                  d.fail = 1'b1;
                  d.busy = 1'b0;
                  set[`DSC_I_FAIL] = 1'b1;
                  d.state = DSC_IDLE;
               end else if (q.step == `DSC_STEP_POLL) begin
                  // RULE_17 lock bit seen
                  if (spi_rdata[`DSC_LOCK_BIT]) begin
                     d.locked = 1'b1;
                     d.done = 1'b1;
                     d.busy = 1'b0;
                     set[`DSC_I_DONE] = 1'b1;
                     set[`DSC_I_LOCK] = 1'b1;
                     d.state = DSC_IDLE;
                  // RULE_19 bounded lock polling
                  end else if (q.polls == LOCK_POLLS - 16'h0001) begin
                     d.fail = 1'b1;
                     d.busy = 1'b0;
                     set[`DSC_I_FAIL] = 1'b1;
                     d.state = DSC_IDLE;
                  end else begin
                     d.polls = q.polls + 16'h0001;
                     d.state = DSC_ISSUE;
                  end
               end else begin
                  d.state = DSC_NEXT;
               end
            end
         end
         DSC_NEXT: begin
            // RULE_11 pll part only on request
            if (q.step == `DSC_STEP_BASE_LAST && !q.use_pll) begin
               d.done = 1'b1;
               d.busy = 1'b0;
               set[`DSC_I_DONE] = 1'b1;
               d.state = DSC_IDLE;
            end else begin
               d.step = q.step + 6'h01;
               d.state = DSC_ISSUE;
            end
         end
         default: d.state = DSC_IDLE;
      endcase

      // new events win over a clearing read
      d.istat = (rd_clr ? 3'h0 : q.istat) | set;
      d.irq = |(d.istat & d.imask);
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   dsc_spi_xfer #(
      .HALF(SCLK_HALF)
   ) u_spi (
      .ref_clk_i(ref_clk_i),
      .reset_n_i(reset_n_i),
      .start_i(q.go),
      .rd_i(cmd[23]),
      .addr_i(cmd[22:8]),
      .wdata_i(cmd[7:0]),
      .sdo_i(spi_sdo_i),
      .done_o(spi_done),
      .rdata_o(spi_rdata),
      .sclk_o(spi_sclk_o),
      .cs_n_o(spi_cs_n_o),
      .sdio_o(spi_sdio_o),
      .sdio_oe_o(spi_sdio_oe_o)
   );

   assign wb_dat_o = q.rdata;
   assign wb_ack_o = q.ack;
   assign irq_o = q.irq;

   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);

   a_soft_reset_first: assert property ( // RULE_05
      $rose(q.busy) |=> q.go && cmd == `DSC_WR(`DSC_A_PORT, `DSC_V_SOFT_RESET))
      else $error("sequence did not open with soft reset");
   a_power_bits_zero: assert property ( // RULE_06
      q.go && cmd[22:8] == `DSC_A_PWR |-> !cmd[23] && !cmd[7] && !cmd[2])
      else $error("band gap or master power-down bit set");
   a_pd_field_zero: assert property ( // RULE_07
      q.go && cmd[22:8] == `DSC_A_PWR && q.pd_dacs == 4'h0 |-> cmd[6:3] == 4'h0)
      else $error("converter power-down field not zero");
   a_align_value: assert property ( // RULE_09
      q.go && cmd[22:8] == `DSC_A_ALIGN_PD
      |-> cmd[7:0] == (q.sub0 ? `DSC_V_ALIGN_SUB0 : `DSC_V_ALIGN_SUB1))
      else $error("alignment input power-down value wrong");
   a_pll_gated: assert property ( // RULE_12
      q.go && cmd[22:8] == `DSC_A_PWR_MACH |-> q.use_pll && cmd[7:0] == 8'h00)
      else $error("power machine write without pll use");
   a_poll_after_en: assert property ( // RULE_16
      q.state == DSC_WAIT && spi_done && q.step == `DSC_STEP_PLL_EN && !q.abort
      |-> ##3 q.go && cmd == `DSC_RD(`DSC_A_PLL_LOCK))
      else $error("lock read does not follow pll enable");
   a_lock_done: assert property ( // RULE_17
      q.state == DSC_WAIT && spi_done && q.step == `DSC_STEP_POLL && !q.abort
      && spi_rdata[`DSC_LOCK_BIT] |=> q.done && q.locked && !q.busy && q.istat[`DSC_I_LOCK])
      else $error("lock bit not reported as done");
   a_poll_bound: assert property ( // RULE_19
      q.busy |-> q.polls < LOCK_POLLS)
      else $error("lock polls exceed bound");
   a_wb_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");
   a_irq_follows: assert property (q.istat == 3'h0 |-> !irq_o)
      else $error("interrupt with no status bit");

endmodule

// *** test/dsc_dev_model.sv ***
`timescale 1ns/1ps
module dsc_dev_model #(
   parameter logic [7:0] TYPE_CODE = 8'h5a, // arbitrary value
   parameter logic [15:0] PROD_ID = 16'h1234, // arbitrary value
   parameter logic [7:0] GRADE_REV = 8'h37 // arbitrary value
) (
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic sdio_i,
   input wire logic lock_ok_i,
   output logic sdo_o,
   output logic pwr_ok_o
);
   logic [7:0] mem [0:1023];
   logic [23:0] sh;
   logic [4:0] cnt;
   logic [7:0] rd_q;
   logic [22:0] wlog [$];
   int lock_reads;
   initial begin
      sdo_o = 1'b0;
      cnt = '0;
      lock_reads = 0;
      foreach (mem[i]) mem[i] = 8'h00;
      // blocks start powered down until the host clears the bits
      mem[10'h011] = 8'h84;
   end
   assign pwr_ok_o = !mem[10'h011][7] && !mem[10'h011][2];
   function automatic logic [7:0] rd_reg(input logic [14:0] a);
      case (a)
         15'h003: return TYPE_CODE;
         15'h004: return PROD_ID[7:0];
         15'h005: return PROD_ID[15:8];
         15'h006: return GRADE_REV;
         15'h084: return {6'h00, mem[10'h083] == 8'h10 && lock_ok_i, 1'b0};
         default: return mem[a[9:0]];
      endcase
   endfunction
   always @(negedge cs_n_i) cnt = '0;
   // released line shows the inverse of its last value
   always @(posedge cs_n_i) sdo_o = ~sdo_o;
   // instruction word, read flag, msb first
   always @(posedge sclk_i) begin
      if (!cs_n_i) begin
         sh = {sh[22:0], sdio_i};
         cnt = cnt + 5'd1;
         if (cnt == 5'd16 && sh[15]) begin
            rd_q = rd_reg(sh[14:0]);
            if (sh[14:0] == 15'h084) lock_reads++;
         end
         if (cnt == 5'd24 && !sh[23]) begin
            wlog.push_back(sh[22:0]);
            if (!(sh[22:8] inside {[15'h003:15'h006], 15'h084})) mem[sh[17:8]] = sh[7:0];
         end
      end
   end
   always @(negedge sclk_i) begin
      if (!cs_n_i && cnt >= 5'd16 && cnt < 5'd24) begin
         sdo_o = rd_q[7];
         rd_q = {rd_q[6:0], 1'b0};
      end
   end
endmodule

// *** test/dac_startup_config_sequencer_test.sv ***
`timescale 1ns/1ps
`include "dsc_defines.svh"
module dac_startup_config_sequencer_test;
   logic ref_clk, reset_n, cyc, stb, we, ack, irq, sclk, cs_n, sdio, oe, sdo, lock_ok, pwr_ok;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] dat_w, dat_r, q;
   wire sdio_w = oe ? sdio : 1'bz;
   int mismatches, checked;
   logic [22:0] expq [$];
   dsc_startup_host #(.LOCK_POLLS(16'd4)) i_dsc_startup_host (.ref_clk_i(ref_clk),
      .reset_n_i(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack), .irq_o(irq),
      .spi_sclk_o(sclk), .spi_cs_n_o(cs_n), .spi_sdio_o(sdio), .spi_sdio_oe_o(oe),
      .spi_sdo_i(sdo));
   dsc_dev_model i_dsc_dev_model (.sclk_i(sclk), .cs_n_i(cs_n), .sdio_i(sdio_w),
      .lock_ok_i(lock_ok), .sdo_o(sdo), .pwr_ok_o(pwr_ok));
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   task conclude;
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task chk(input string what, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= d;
      sel <= 4'hf;
      do begin
         @(posedge ref_clk);
         n++;
      end while (ack !== 1'b1 && n < 100);
      q = dat_r;
      if (n >= 100) begin
         chk("ack", 1, 0);
         conclude();
      end
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task rd_chk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(what, e, q & m);
   endtask
   task wait_irq;
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 30000) begin
         @(posedge ref_clk);
         n++;
      end
      chk("irq raised", 1, irq);
      if (irq !== 1'b1) conclude();
   endtask
   task ex(input logic [14:0] a, input logic [7:0] v);
      expq.push_back({a, v});
   endtask
   task exp_base(input logic [7:0] p, input logic [7:0] c, input logic [7:0] s);
      expq.delete();
      i_dsc_dev_model.wlog.delete();
      ex(15'h000, 8'hbd);
      ex(15'h000, 8'h3c);
      ex(15'h011, p);
      ex(15'h080, c);
      ex(15'h081, s);
      ex(15'h12d, 8'h8b);
      ex(15'h146, 8'h01);
      ex(15'h2a4, 8'hff);
      ex(15'h232, 8'hff);
      ex(15'h333, 8'h01);
   endtask
   task cmp_log;
      chk("write count", expq.size(), i_dsc_dev_model.wlog.size());
      for (int i = 0; i < expq.size(); i++) chk("write", expq[i], i_dsc_dev_model.wlog[i]);
   endtask
   task test_regs;
      rd_chk("status", `DSC_R_STATUS, 32'hf, 0);
      rd_chk("unmapped", 8'h20, 32'hffffffff, 0);
      wb(1'b1, `DSC_R_IMASK, 32'h7);
      rd_chk("imask", `DSC_R_IMASK, 32'h7, 7);
      chk("irq idle", 0, irq);
      $display("test regs done");
   endtask
   task test_base;
      lock_ok <= 1'b1;
      wb(1'b1, `DSC_R_IMASK, 32'h1);
      exp_base(8'h00, 8'h00, 8'h00);
      wb(1'b1, `DSC_R_CTRL, 32'h1);
      wait_irq();
      cmp_log();
      rd_chk("ident", `DSC_R_IDENT, 32'hffffffff, 32'h3712345a);
      rd_chk("status", `DSC_R_STATUS, 32'hf, 32'h2);
      rd_chk("istat", `DSC_R_ISTAT, 32'h7, 32'h1);
      rd_chk("istat cleared", `DSC_R_ISTAT, 32'h7, 32'h0);
      chk("irq cleared", 0, irq);
      chk("powered", 1, pwr_ok);
      $display("test base done");
   endtask
   task test_pll;
      wb(1'b1, `DSC_R_PWRCFG, 32'h0f05);
      wb(1'b1, `DSC_R_PLLDIV, 32'h030201);
      wb(1'b1, `DSC_R_LOOKUP, 32'h012355);
      exp_base(8'h28, 8'h0f, 8'h10);
      ex(15'h087, 8'h62);
      ex(15'h088, 8'hc9);
      ex(15'h089, 8'h0e);
      ex(15'h08a, 8'h12);
      ex(15'h08d, 8'h7b);
      ex(15'h1b0, 8'h00);
      ex(15'h1b9, 8'h24);
      ex(15'h1bc, 8'h0d);
      ex(15'h1be, 8'h02);
      ex(15'h1bf, 8'h8e);
      ex(15'h1c0, 8'h2a);
      ex(15'h1c1, 8'h2a);
      ex(15'h1c4, 8'h7e);
      ex(15'h08b, 8'h01);
      ex(15'h08c, 8'h02);
      ex(15'h085, 8'h03);
      ex(15'h123, 8'h55);
      ex(15'h083, 8'h10);
      wb(1'b1, `DSC_R_CTRL, 32'h7);
      wait_irq();
      cmp_log();
      chk("lock polled", 1, i_dsc_dev_model.lock_reads > 0);
      rd_chk("status", `DSC_R_STATUS, 32'hf, 32'ha);
      rd_chk("istat", `DSC_R_ISTAT, 32'h7, 32'h5);
      $display("test pll done");
   endtask
   task test_nolock;
      lock_ok <= 1'b0;
      i_dsc_dev_model.lock_reads = 0;
      wb(1'b1, `DSC_R_PWRCFG, 32'h0);
      wb(1'b1, `DSC_R_IMASK, 32'h2);
      wb(1'b1, `DSC_R_CTRL, 32'h3);
      wait_irq();
      chk("lock polls", 4, i_dsc_dev_model.lock_reads);
      rd_chk("status", `DSC_R_STATUS, 32'hc, 32'h4);
      wb(1'b1, `DSC_R_IMASK, 32'h0);
      repeat (2) @(posedge ref_clk);
      chk("irq masked", 0, irq);
      rd_chk("istat", `DSC_R_ISTAT, 32'h2, 32'h2);
      $display("test nolock done");
   endtask
   task test_abort;
      wb(1'b1, `DSC_R_IMASK, 32'h2);
      wb(1'b1, `DSC_R_CTRL, 32'h1);
      wb(1'b1, `DSC_R_CTRL, 32'h8);
      wait_irq();
      rd_chk("abort status", `DSC_R_STATUS, 32'hf, 32'h4);
      rd_chk("abort istat", `DSC_R_ISTAT, 32'h7, 32'h2);
      $display("test abort done");
   endtask
   initial begin
      {reset_n, cyc, stb, we, lock_ok} = '0;
      {adr, sel, dat_w} = '0;
      mismatches = 0;
      checked = 0;
      repeat (8) @(posedge ref_clk);
      reset_n <= 1'b1;
      test_regs();
      test_base();
      test_pll();
      test_nolock();
      test_abort();
      conclude();
   end
   initial begin
      repeat (90000) @(posedge ref_clk);
      mismatches++;
      conclude();
   end
endmodule
